// ===== hw/syc_regs.svh
// register offsets, field positions, keys and reset values of the system control bank
`ifndef SYC_REGS_SVH
`define SYC_REGS_SVH

// ==================================================
// offsets (byte addresses on the APB side)
`define SYC_OFF_VTB        8'h00
`define SYC_OFF_APP        8'h04
`define SYC_OFF_LPC        8'h08
`define SYC_OFF_CFG        8'h0C
`define SYC_OFF_STAT       8'h10

// ==================================================
// vector table base fields
`define SYC_VTB_LSB        7
`define SYC_VTB_MSB        29
`define SYC_VTB_RST        23'h000000

// ==================================================
// interrupt and reset control fields
`define SYC_KEY_WRITE      16'h05FA
`define SYC_KEY_STATUS     16'hFA05
`define SYC_APP_KEY_LSB    16
`define SYC_APP_ENDIAN_BIT 15
`define SYC_APP_GRP_LSB    8
`define SYC_APP_GRP_MSB    10
`define SYC_APP_RESET_BIT  2
`define SYC_GRP_RST        3'h0

// ==================================================
// low-power control fields
`define SYC_LPC_EVPEND_BIT 4
`define SYC_LPC_DEEP_BIT   2
`define SYC_LPC_EXIT_BIT   1

// ==================================================
// configuration control fields
`define SYC_CFG_STK_BIT    9
`define SYC_CFG_BFIGN_BIT  8
`define SYC_CFG_DIV_BIT    4
`define SYC_CFG_UNAL_BIT   3
`define SYC_CFG_STK_RST    1'b1

// ==================================================
// status fields
`define SYC_STAT_LATCH_BIT 0
`define SYC_STAT_WAIT_BIT  1
`define SYC_STAT_RST_BIT   2

`endif

// ===== hw/syc_pkg.sv
// types shared by the system control bank
package syc_pkg;
	typedef logic [7:0] syc_prio_t;
	typedef logic [2:0] syc_group_t;
	typedef enum logic [2:0] {
		SYC_FLT_NONE,
		SYC_FLT_USAGE,
		SYC_FLT_BUS,
		SYC_FLT_MEM,
		SYC_FLT_HARD,
		SYC_FLT_LOCKUP
	} syc_fault_t;
	typedef enum logic {
		SYC_RUN,
		SYC_WAIT
	} syc_wfe_t;
endpackage

// ===== hw/syc_prio_split.sv
// splits one priority byte into group priority and subpriority
`timescale 1ns/1ps
module syc_prio_split #(
	parameter int PRIO_BITS = 8
) (
	input  wire syc_pkg::syc_prio_t  priority_byte,
	input  wire syc_pkg::syc_group_t priority_grouping,
	output wire syc_pkg::syc_prio_t  group_prio,
	output wire syc_pkg::syc_prio_t  sub_prio
);
	// ==================================================
	// masks
	function automatic syc_pkg::syc_prio_t group_mask(input syc_pkg::syc_group_t n);
		group_mask = 8'(8'hFF << (4'(n) + 4'h1));
	endfunction

	wire syc_pkg::syc_prio_t impl_mask = 8'(8'hFF << (8 - PRIO_BITS));
	wire syc_pkg::syc_prio_t masked    = priority_byte & impl_mask;
	assign group_prio = masked & group_mask(priority_grouping);
	assign sub_prio   = masked & ~group_mask(priority_grouping);
endmodule // syc_prio_split

// ===== hw/syc_system_ctrl.sv
// system control register bank: vector base, reset control, low power, configuration traps
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "syc_regs.svh"
module syc_system_ctrl #(
	parameter int       PRIO_BITS  = 8,
	parameter bit       BIG_ENDIAN = 1'b0
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output wire logic                pready,
	output logic      [31:0]         prdata,
	output wire logic                pslverr,
	input  wire logic [8:0]          exc_num,
	output logic      [31:0]         vector_fetch_addr,
	output wire logic                table_in_sram,
	input  wire syc_pkg::syc_prio_t  pend_prio,
	input  wire syc_pkg::syc_prio_t  active_prio,
	input  wire logic                active_valid,
	output wire logic                preempt_ok,
	output wire syc_pkg::syc_prio_t  pend_group_prio,
	output wire syc_pkg::syc_prio_t  pend_sub_prio,
	output logic                     system_reset_request,
	input  wire logic                irq_pend_rise,
	input  wire logic                irq_enabled,
	input  wire logic                send_event_instr,
	input  wire logic                ext_event,
	input  wire logic                wait_for_event_instr,
	output wire logic                core_waiting,
	output logic                     wake_pulse,
	output wire logic                deep_sleep_select,
	input  wire logic                handler_exit,
	output logic                     sleep_on_exit_pulse,
	input  wire logic                exc_entry,
	input  wire logic                sp_bit2,
	output logic                     stacked_psr_bit9,
	input  wire logic                exc_return,
	input  wire logic                stacked_bit9_in,
	output logic                     restore_adjust,
	input  wire logic                data_bus_fault,
	input  wire logic                prio_negative,
	input  wire logic                div_zero,
	output logic                     quotient_zero,
	input  wire logic                unaligned_access,
	input  wire logic                multi_or_double,
	input  wire logic                mem_fault_in,
	input  wire logic                usage_fault_en,
	input  wire logic                bus_fault_en,
	input  wire logic                mem_fault_en,
	output syc_pkg::syc_fault_t      fault_kind
);
	// ==================================================
	// state
	logic [22:0]         vtb_q;
	syc_pkg::syc_group_t grp_q;
	logic                rst_req_q;
	logic                evpend_q, deep_q, exit_q;
	logic                stk_q, bfign_q, div_q, unal_q;
	logic                latch_q, latch_d;
	syc_pkg::syc_wfe_t   wfe_q, wfe_d;

	// ==================================================
	// APB decode
	wire acc      = psel & penable;
	wire wr       = acc & pwrite;
	wire setup    = psel & ~penable;
	wire hit_vtb  = paddr == `SYC_OFF_VTB;
	wire hit_app  = paddr == `SYC_OFF_APP;
	wire hit_lpc  = paddr == `SYC_OFF_LPC;
	wire hit_cfg  = paddr == `SYC_OFF_CFG;
	wire hit_stat = paddr == `SYC_OFF_STAT;
	wire hit_any  = hit_vtb | hit_app | hit_lpc | hit_cfg | hit_stat;
	// read data is staged in setup, so the access phase never waits
	assign pready  = acc;
	assign pslverr = acc & ~hit_any;

	wire key_ok = pwdata[31:`SYC_APP_KEY_LSB] == `SYC_KEY_WRITE;
	wire wr_app = wr & hit_app & key_ok;

	// ==================================================
	// read mux
	// offset low bits read zero
	wire [31:0] rd_vtb = {2'h0, vtb_q, 7'h00};
	wire [31:0] rd_app = {`SYC_KEY_STATUS, BIG_ENDIAN, 4'h0, grp_q, 8'h00};
	wire [31:0] rd_lpc = {27'h0, evpend_q, 1'b0, deep_q, exit_q, 1'b0};
	wire [31:0] rd_cfg = {22'h0, stk_q, bfign_q, 3'h0, div_q, unal_q, 3'h0};
	wire [31:0] rd_stat = {29'h0, rst_req_q, core_waiting, latch_q};
	wire [31:0] rd_mux = hit_vtb ? rd_vtb :
		hit_app ? rd_app :
		hit_lpc ? rd_lpc :
		hit_cfg ? rd_cfg :
		hit_stat ? rd_stat : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// ==================================================
	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vtb_q <= `SYC_VTB_RST;
			grp_q <= `SYC_GRP_RST;
		end else begin
			if (wr && hit_vtb) begin
				vtb_q <= pwdata[`SYC_VTB_MSB:`SYC_VTB_LSB];
			end
			if (wr_app) begin
				grp_q <= pwdata[`SYC_APP_GRP_MSB:`SYC_APP_GRP_LSB];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evpend_q <= 1'b0;
			deep_q   <= 1'b0;
			exit_q   <= 1'b0;
		end else if (wr && hit_lpc) begin
			evpend_q <= pwdata[`SYC_LPC_EVPEND_BIT];
			deep_q   <= pwdata[`SYC_LPC_DEEP_BIT];
			exit_q   <= pwdata[`SYC_LPC_EXIT_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stk_q   <= `SYC_CFG_STK_RST;
			bfign_q <= 1'b0;
			div_q   <= 1'b0;
			unal_q  <= 1'b0;
		end else if (wr && hit_cfg) begin
			stk_q   <= pwdata[`SYC_CFG_STK_BIT];
			bfign_q <= pwdata[`SYC_CFG_BFIGN_BIT];
			div_q   <= pwdata[`SYC_CFG_DIV_BIT];
			unal_q  <= pwdata[`SYC_CFG_UNAL_BIT];
		end
	end

	// ==================================================
	// reset request
	// keyed write of bit 2 raises request
	// only the block's own reset drops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_req_q <= 1'b0;
		end else if (wr_app && pwdata[`SYC_APP_RESET_BIT]) begin
			rst_req_q <= 1'b1;
		end
	end
	assign system_reset_request = rst_req_q;

	// ==================================================
	// vector table
	// region bit is the top stored bit
	assign table_in_sram = vtb_q[`SYC_VTB_MSB - `SYC_VTB_LSB];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_fetch_addr <= 32'h0000_0000;
		end else begin
			vector_fetch_addr <= rd_vtb + {21'h0, exc_num, 2'b00};
		end
	end

	// ==================================================
	// priority grouping
	syc_pkg::syc_prio_t act_group;
	syc_prio_split #(.PRIO_BITS(PRIO_BITS)) u_split_pend (
		.priority_byte     (pend_prio),
		.priority_grouping (grp_q),
		.group_prio        (pend_group_prio),
		.sub_prio          (pend_sub_prio)
	);
	syc_prio_split #(.PRIO_BITS(PRIO_BITS)) u_split_act (
		.priority_byte     (active_prio),
		.priority_grouping (grp_q),
		.group_prio        (act_group),
		.sub_prio          ()
	);
	// lower group number preempts, subpriority ignored
	assign preempt_ok = !active_valid || (pend_group_prio < act_group);

	// ==================================================
	// wait-for-event
	// disabled interrupts count only with event-on-pending
	// send-event and external event wake too
	wire wake_ev = (irq_pend_rise && (irq_enabled || evpend_q)) || send_event_instr || ext_event;
	wire running = wfe_q == syc_pkg::SYC_RUN;
	wire consume = running && wait_for_event_instr;
	// latch when not waiting, the consuming wait beats the set
	assign latch_d = (running && wake_ev && !wait_for_event_instr) ? 1'b1 :
		consume ? 1'b0 : latch_q;

	always_comb begin
		wfe_d = wfe_q;
		unique case (wfe_q)
			syc_pkg::SYC_RUN: begin
				if (consume && !latch_q && !wake_ev) begin
					wfe_d = syc_pkg::SYC_WAIT;
				end
			end
			syc_pkg::SYC_WAIT: begin
				if (wake_ev) begin
					wfe_d = syc_pkg::SYC_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wfe_q      <= syc_pkg::SYC_RUN;
			latch_q    <= 1'b0;
			wake_pulse <= 1'b0;
		end else begin
			wfe_q      <= wfe_d;
			latch_q    <= latch_d;
			// wake from wait or from a latched event
			wake_pulse <= (!running && wake_ev) || (consume && (latch_q || wake_ev));
		end
	end
	assign core_waiting = !running;

	// ==================================================
	// sleep controls
	// deep sleep select
	assign deep_sleep_select = deep_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_on_exit_pulse <= 1'b0;
		end else begin
			sleep_on_exit_pulse <= handler_exit && exit_q;
		end
	end

	// ==================================================
	// stack alignment
	// record and restore the adjustment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stacked_psr_bit9 <= 1'b0;
			restore_adjust   <= 1'b0;
		end else begin
			if (exc_entry) begin
				stacked_psr_bit9 <= stk_q && sp_bit2;
			end
			restore_adjust <= exc_return && stacked_bit9_in;
		end
	end

	// ==================================================
	// fault routing
	// negative-priority data bus faults ignored or lock up
	wire bus_neg   = data_bus_fault && prio_negative;
	wire bus_plain = data_bus_fault && !prio_negative;
	// zero divide traps only when enabled
	wire div_trap  = div_zero && div_q;
	wire unal_trap = unaligned_access && (unal_q || multi_or_double);
	wire usage_ev  = div_trap || unal_trap;
	wire escalate  = (usage_ev && !usage_fault_en) || (bus_plain && !bus_fault_en) ||
		(mem_fault_in && !mem_fault_en);
	syc_pkg::syc_fault_t fault_d;
	assign fault_d = (bus_neg && !bfign_q) ? syc_pkg::SYC_FLT_LOCKUP :
		escalate ? syc_pkg::SYC_FLT_HARD :
		bus_plain ? syc_pkg::SYC_FLT_BUS :
		mem_fault_in ? syc_pkg::SYC_FLT_MEM :
		usage_ev ? syc_pkg::SYC_FLT_USAGE : syc_pkg::SYC_FLT_NONE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_kind    <= syc_pkg::SYC_FLT_NONE;
			quotient_zero <= 1'b0;
		end else begin
			fault_kind    <= fault_d;
			quotient_zero <= div_zero && !div_q;
		end
	end

	// ==================================================
	// checks
	key_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && hit_app && !key_ok) |=> (grp_q == $past(grp_q) && rst_req_q == $past(rst_req_q)))
		else $error("unkeyed write changed reset control");
	key_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_app) |=> (prdata[31:16] == `SYC_KEY_STATUS && prdata[2:0] == 3'h0))
		else $error("reset control read wrong upper half");
	vtb_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && hit_vtb) |=> prdata[6:0] == 7'h00)
		else $error("table offset low bits not zero");
	reset_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_app && pwdata[`SYC_APP_RESET_BIT]) |=> system_reset_request [*4])
		else $error("reset request not raised");
	reset_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		system_reset_request |=> system_reset_request)
		else $error("reset request dropped");
	wait_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		(core_waiting && ext_event) |=> (wake_pulse && !core_waiting))
		else $error("external event did not wake");
	latch_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!core_waiting && send_event_instr && !wait_for_event_instr) ##1
		(wait_for_event_instr && !core_waiting) |=> (wake_pulse && !core_waiting))
		else $error("latched event lost");
	disabled_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		(core_waiting && irq_pend_rise && !irq_enabled && !evpend_q && !send_event_instr && !ext_event)
		|=> (!wake_pulse && core_waiting))
		else $error("disabled interrupt woke core");
	div_trap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(div_zero && !div_q && !unaligned_access && !data_bus_fault && !mem_fault_in)
		|=> (quotient_zero && fault_kind == syc_pkg::SYC_FLT_NONE))
		else $error("untrapped zero divide faulted");
	unal_multi_a: assert property (@(posedge pclk) disable iff (!presetn)
		(unaligned_access && multi_or_double && usage_fault_en && !data_bus_fault && !mem_fault_in)
		|=> fault_kind == syc_pkg::SYC_FLT_USAGE)
		else $error("unaligned multiple did not fault");
	preempt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(active_valid && pend_group_prio == act_group) |-> !preempt_ok)
		else $error("equal group preempted");
endmodule // syc_system_ctrl

// ===== dv/system_control_regs_test.sv
// self-checking testbench for the system control register bank
`timescale 1ns/1ps
`include "syc_regs.svh"
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module system_control_regs_test;
	logic                pclk      = 1'b0;
	logic                presetn   = 1'b0;
	logic                psel      = 1'b0;
	logic                penable   = 1'b0;
	logic                pwrite    = 1'b0;
	logic [7:0]          paddr     = 8'h00;
	logic [31:0]         pwdata    = 32'h00000000;
	logic [8:0]          exc_num   = 9'h000;
	syc_pkg::syc_prio_t  pend_prio = 8'h00;
	syc_pkg::syc_prio_t  active_prio = 8'h00;
	logic                active_valid = 1'b0;
	logic                irq_enabled = 1'b0;
	logic                sp_bit2   = 1'b0;
	logic                stacked_bit9_in = 1'b0;
	logic                prio_negative = 1'b0;
	logic                multi_or_double = 1'b0;
	logic [2:0]          fen       = 3'h7;
	// pulse inputs: 0 irq, 1 sev, 2 ext, 3 wfe, 4 hexit, 5 entry, 6 return, 7 dbus, 8 div0, 9 unal, 10 mem
	logic [10:0]         pv        = 11'h000;
	wire                 pready;
	wire                 pslverr;
	logic [31:0]         prdata;
	logic [31:0]         vector_fetch_addr;
	wire                 table_in_sram;
	wire                 preempt_ok;
	wire syc_pkg::syc_prio_t pend_group_prio;
	wire syc_pkg::syc_prio_t pend_sub_prio;
	wire                 core_waiting;
	logic                wake_pulse;
	wire                 deep_sleep_select;
	logic                sleep_on_exit_pulse;
	logic                system_reset_request;
	logic                stacked_psr_bit9;
	logic                restore_adjust;
	logic                quotient_zero;
	syc_pkg::syc_fault_t fault_kind;
	logic [31:0]         r;
	logic                last_err;
	int                  failures  = 0;
	int                  checks_done = 0;
	int                  cycles    = 0;

	always #10 pclk = ~pclk;

	syc_system_ctrl u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.exc_num(exc_num), .vector_fetch_addr(vector_fetch_addr), .table_in_sram(table_in_sram),
		.pend_prio(pend_prio), .active_prio(active_prio), .active_valid(active_valid),
		.preempt_ok(preempt_ok), .pend_group_prio(pend_group_prio), .pend_sub_prio(pend_sub_prio),
		.system_reset_request(system_reset_request), .irq_pend_rise(pv[0]), .irq_enabled(irq_enabled),
		.send_event_instr(pv[1]), .ext_event(pv[2]), .wait_for_event_instr(pv[3]),
		.core_waiting(core_waiting), .wake_pulse(wake_pulse), .deep_sleep_select(deep_sleep_select),
		.handler_exit(pv[4]), .sleep_on_exit_pulse(sleep_on_exit_pulse), .exc_entry(pv[5]),
		.sp_bit2(sp_bit2), .stacked_psr_bit9(stacked_psr_bit9), .exc_return(pv[6]),
		.stacked_bit9_in(stacked_bit9_in), .restore_adjust(restore_adjust), .data_bus_fault(pv[7]),
		.prio_negative(prio_negative), .div_zero(pv[8]), .quotient_zero(quotient_zero),
		.unaligned_access(pv[9]), .multi_or_double(multi_or_double), .mem_fault_in(pv[10]),
		.usage_fault_en(fen[0]), .bus_fault_en(fen[1]), .mem_fault_en(fen[2]), .fault_kind(fault_kind)
	);

	// ==================================================
	// run control
	task automatic complete_run();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// the whole run needs well under this many cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			$display("[FAIL] %0t run did not finish", $time);
			complete_run();
		end
	end

	// ==================================================
	// bus and pulse helpers
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed: poll pready at each rising edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q        = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
		// register outputs settle after the capturing edge
		#1;
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h00000000, r);
	endtask

	// drive one cycle of pulses, sample registered outputs after the capturing edge
	task automatic pulse(input logic [10:0] m);
		@(posedge pclk);
		pv <= m;
		@(posedge pclk);
		pv <= 11'h000;
		#1;
	endtask

	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	task automatic prio(input logic [7:0] p, input logic [7:0] a, input logic v, input logic exp);
		@(posedge pclk);
		pend_prio    <= p;
		active_prio  <= a;
		active_valid <= v;
		#1;
		`CHK(preempt_ok, exp)
	endtask

	// ==================================================
	// scenarios
	task automatic t_reset_values();
		rd(`SYC_OFF_VTB);  `CHK(r, 32'h00000000)
		rd(`SYC_OFF_APP);  `CHK(r, 32'hFA050000)
		rd(`SYC_OFF_LPC);  `CHK(r, 32'h00000000)
		rd(`SYC_OFF_CFG);  `CHK(r, 32'h00000200)
		`CHK(system_reset_request, 1'b0)
		rd(8'h14);         `CHK(r, 32'h00000000)
		`CHK(last_err, 1'b1)
	endtask

	task automatic t_vector_base();
		wr(`SYC_OFF_VTB, 32'hFFFFFFFF);
		rd(`SYC_OFF_VTB);  `CHK(r, 32'h3FFFFF80)
		`CHK(last_err, 1'b0)
		wr(`SYC_OFF_VTB, 32'h20000100);
		`CHK(table_in_sram, 1'b1)
		exc_num <= 9'h010;
		repeat (3) @(posedge pclk);
		#1;
		`CHK(vector_fetch_addr, 32'h20000140)
		wr(`SYC_OFF_VTB, 32'h00000080);
		`CHK(table_in_sram, 1'b0)
	endtask

	task automatic t_key_and_grouping();
		// write without the key must change nothing, not even the reset request
		wr(`SYC_OFF_APP, 32'h00000504);
		rd(`SYC_OFF_APP);  `CHK(r, 32'hFA050000)
		`CHK(system_reset_request, 1'b0)
		wr(`SYC_OFF_APP, 32'h05FAFFF8);
		rd(`SYC_OFF_APP);  `CHK(r, 32'hFA050700)
		prio(8'h00, 8'hFF, 1'b1, 1'b0);
		prio(8'h00, 8'hFF, 1'b0, 1'b1);
		wr(`SYC_OFF_APP, 32'h05FA0500);
		rd(`SYC_OFF_APP);  `CHK(r, 32'hFA050500)
		prio(8'h40, 8'h7F, 1'b1, 1'b0);
		prio(8'h3F, 8'h40, 1'b1, 1'b1);
		`CHK(pend_group_prio, 8'h00)
		`CHK(pend_sub_prio, 8'h3F)
		prio(8'h80, 8'h40, 1'b1, 1'b0);
		`CHK(pend_group_prio, 8'h80)
		`CHK(pend_sub_prio, 8'h00)
	endtask

	task automatic t_reset_request();
		wr(`SYC_OFF_APP, 32'h05FA0004);
		`CHK(system_reset_request, 1'b1)
		rd(`SYC_OFF_APP);  `CHK(r, 32'hFA050000)
		rd(`SYC_OFF_STAT); `CHK(r, 32'h00000004)
		repeat (20) @(posedge pclk);
		#1;
		`CHK(system_reset_request, 1'b1)
		do_reset();
		#1;
		`CHK(system_reset_request, 1'b0)
	endtask

	task automatic t_wait_for_event();
		pulse(11'h008); `CHK(core_waiting, 1'b1)
		// disabled interrupt must not wake while event-on-pending is clear
		pulse(11'h001); `CHK(wake_pulse, 1'b0)
		`CHK(core_waiting, 1'b1)
		pulse(11'h004); `CHK(wake_pulse, 1'b1)
		`CHK(core_waiting, 1'b0)
		// event while running is latched and satisfies the very next wait
		@(posedge pclk);
		pv <= 11'h002;
		@(posedge pclk);
		pv <= 11'h008;
		#1;
		`CHK(wake_pulse, 1'b0)
		@(posedge pclk);
		pv <= 11'h000;
		#1;
		`CHK(wake_pulse, 1'b1)
		`CHK(core_waiting, 1'b0)
		wr(`SYC_OFF_LPC, 32'hFFFFFFFF);
		rd(`SYC_OFF_LPC);  `CHK(r, 32'h00000016)
		`CHK(deep_sleep_select, 1'b1)
		pulse(11'h008); `CHK(core_waiting, 1'b1)
		pulse(11'h001); `CHK(wake_pulse, 1'b1)
		pulse(11'h010); `CHK(sleep_on_exit_pulse, 1'b1)
		wr(`SYC_OFF_LPC, 32'h00000000);
		`CHK(deep_sleep_select, 1'b0)
		pulse(11'h010); `CHK(sleep_on_exit_pulse, 1'b0)
		// enabled interrupt wakes with event-on-pending clear
		irq_enabled <= 1'b1;
		pulse(11'h008); `CHK(core_waiting, 1'b1)
		pulse(11'h001); `CHK(wake_pulse, 1'b1)
		`CHK(core_waiting, 1'b0)
		irq_enabled <= 1'b0;
	endtask

	task automatic t_stack_and_faults();
		sp_bit2 <= 1'b1;
		pulse(11'h020); `CHK(stacked_psr_bit9, 1'b1)
		stacked_bit9_in <= 1'b1;
		pulse(11'h040); `CHK(restore_adjust, 1'b1)
		wr(`SYC_OFF_CFG, 32'hFFFFFDFF);
		rd(`SYC_OFF_CFG);  `CHK(r, 32'h00000118)
		pulse(11'h020); `CHK(stacked_psr_bit9, 1'b0)
		pulse(11'h100); `CHK(fault_kind, syc_pkg::SYC_FLT_USAGE)
		pulse(11'h200); `CHK(fault_kind, syc_pkg::SYC_FLT_USAGE)
		prio_negative <= 1'b1;
		pulse(11'h080); `CHK(fault_kind, syc_pkg::SYC_FLT_NONE)
		wr(`SYC_OFF_CFG, 32'h00000000);
		pulse(11'h080); `CHK(fault_kind, syc_pkg::SYC_FLT_LOCKUP)
		prio_negative <= 1'b0;
		pulse(11'h080); `CHK(fault_kind, syc_pkg::SYC_FLT_BUS)
		pulse(11'h100); `CHK(quotient_zero, 1'b1)
		`CHK(fault_kind, syc_pkg::SYC_FLT_NONE)
		pulse(11'h200); `CHK(fault_kind, syc_pkg::SYC_FLT_NONE)
		multi_or_double <= 1'b1;
		pulse(11'h200); `CHK(fault_kind, syc_pkg::SYC_FLT_USAGE)
		pulse(11'h400); `CHK(fault_kind, syc_pkg::SYC_FLT_MEM)
		// each disabled fault class escalates instead of being taken
		fen <= 3'h6;
		pulse(11'h200); `CHK(fault_kind, syc_pkg::SYC_FLT_HARD)
		fen <= 3'h5;
		pulse(11'h080); `CHK(fault_kind, syc_pkg::SYC_FLT_HARD)
		fen <= 3'h3;
		pulse(11'h400); `CHK(fault_kind, syc_pkg::SYC_FLT_HARD)
		fen <= 3'h7;
		multi_or_double <= 1'b0;
	endtask

	// ==================================================
	// main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_wait_for_event();
		t_vector_base();
		t_key_and_grouping();
		t_reset_request();
		t_reset_values();
		t_stack_and_faults();
		complete_run();
	end
endmodule // system_control_regs_test
